// ---- rtl/cfb_pkg.sv ----
// Overview of operation
// - An 8-bit receive error count sits in status bits 31:24 and rises by 1 or 8 on a receive error.
// - A good reception lowers the receive count by 1, or loads 120 when it was above 127.
// - The error passive flag in bit 1 is set while either count exceeds 127.
// - A 9-bit transmit error count is kept and only its low byte shows in bits 23:16.
// - When the transmit count passes 255 the node goes bus-off and sets bit 2.
// - The error warning flag in bit 0 is set while either count is 96 or more.
// - A detected bus error writes its 3-bit code (1 to 6) into bits 6:4.
// - A message sent or received without error clears the last error code to zero.
// - Hardware never writes code 7; software may write 7 to spot a later update.
// - The bit timing register takes writes only in initialization mode.
// - Bit 31 selects silent mode and bit 30 selects loopback mode.
// - Bits 25:24 plus one give the resynchronisation jump width in quanta.
// - Bits 22:20 plus one give the length of time segment 2 in quanta.
// - Bits 19:16 plus one give the length of time segment 1 in quanta.
// - Bits 9:0 plus one give the quantum length in clock periods.
// - Bus-off, passive, warning and code updates set the general error flag through their enables.
package cfb_pkg;
	localparam logic [7:0] ADDR_ERR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_BIT_TIMING = 8'h1c;
	localparam logic [7:0] ADDR_CONTROL = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
	localparam logic [31:0] BIT_TIMING_RST = 32'h01230000;
	localparam logic [31:0] BIT_TIMING_WMASK = 32'hc37f03ff;
	localparam int RX_CNT_LSB = 24;
	localparam int TX_CNT_LSB = 16;
	localparam int LEC_LSB = 4;
	localparam int BOFF_BIT = 2;
	localparam int PASSIVE_BIT = 1;
	localparam int WARN_BIT = 0;
	localparam int SILENT_BIT = 31;
	localparam int LOOPBACK_BIT = 30;
	localparam int SJW_LSB = 24;
	localparam int SEG2_LSB = 20;
	localparam int SEG1_LSB = 16;
	localparam int CTL_INIT_BIT = 0;
	localparam int CTL_WARN_IE = 8;
	localparam int CTL_PASS_IE = 9;
	localparam int CTL_BOFF_IE = 10;
	localparam int CTL_LEC_IE = 11;
	localparam int CTL_ERR_IE = 15;
	localparam logic [31:0] CONTROL_RST = 32'h00000001;
	localparam logic [31:0] CONTROL_WMASK = 32'h00008f01;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h07f;
	localparam logic [8:0] WARN_LIMIT = 9'h060;
	localparam logic [8:0] BOFF_LIMIT = 9'h0ff;
	localparam logic [7:0] RX_RELOAD = 8'h78;
	localparam logic [2:0] LEC_NONE = 3'h0;
	localparam logic [2:0] LEC_SW = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int IRQ_BITS = 2;
	localparam int IRQ_ERR = 0;
	localparam int IRQ_SAMPLE = 1;
	typedef enum logic [1:0] {
		SEG_SYNC,
		SEG_ONE,
		SEG_TWO
	} cfb_seg_t;
endpackage

// ---- rtl/cfb_top.sv ----
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
module cfb_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// protocol engine events
	input wire logic rx_err_1,
	input wire logic rx_err_8,
	input wire logic rx_ok,
	input wire logic tx_err_8,
	input wire logic tx_ok,
	input wire logic bus_err,
	input wire logic [2:0] bus_err_code,
	// timing and mode outputs to protocol engine, status flags and irq
	output logic tq_tick,
	output logic sample_point,
	output logic bit_start,
	output logic [2:0] jump_limit,
	output logic silent_select,
	output logic loopback_select,
	output logic bus_off_flag,
	output logic error_passive_flag,
	output logic irq
);
	logic [7:0] receive_error_count_r;
	logic [8:0] transmit_error_count_r;
	logic [2:0] last_error_code_r;
	logic bus_off_flag_r;
	logic error_warning_flag;
	logic [31:0] bit_timing_r;
	logic [31:0] control_r;
	logic general_error_irq_flag_r;
	logic [1:0] irq_status_r;
	logic [1:0] irq_mask_r;
	logic [1:0] irq_set;
	logic [9:0] presc_cnt_r;
	logic [3:0] seg_cnt_r;
	cfb_pkg::cfb_seg_t seg_r;
	logic passive_d_r;
	logic warn_d_r;
	logic [7:0] aw_addr_r;
	logic aw_have_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic w_have_r;
	logic wr_go;
	logic [31:0] wmask;
	logic [8:0] rx_ext;
	logic passive_now;
	logic warn_now;
	logic lec_event;
	logic err_event;
	logic [31:0] err_status;
	logic [31:0] rd_val;
	logic rd_hit;
	logic wr_hit;

	// byte enables to bit mask
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{w_strb_r[i]}};
		end
	end

	// write channel capture, either order
	assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
	assign s_axi_wready = !w_have_r && !s_axi_bvalid;
	assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_have_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_have_r <= 1'b0;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_go) begin
			w_have_r <= 1'b0;
		end
	end

	always_comb begin
		case (aw_addr_r)
			cfb_pkg::ADDR_ERR_STATUS,
			cfb_pkg::ADDR_BIT_TIMING,
			cfb_pkg::ADDR_CONTROL,
			cfb_pkg::ADDR_IRQ_STATUS,
			cfb_pkg::ADDR_IRQ_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cfb_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? cfb_pkg::RESP_OKAY : cfb_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control: init mode and error enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			control_r <= cfb_pkg::CONTROL_RST;
		end else if (wr_go && aw_addr_r == cfb_pkg::ADDR_CONTROL) begin
			control_r <= (control_r & ~(wmask & cfb_pkg::CONTROL_WMASK))
				| (w_data_r & wmask & cfb_pkg::CONTROL_WMASK);
		end
	end

	// bit timing, writable in init mode only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bit_timing_r <= cfb_pkg::BIT_TIMING_RST;
		end else if (wr_go && aw_addr_r == cfb_pkg::ADDR_BIT_TIMING
			&& control_r[cfb_pkg::CTL_INIT_BIT]) begin
			bit_timing_r <= (bit_timing_r
				& ~(wmask & cfb_pkg::BIT_TIMING_WMASK))
				| (w_data_r & wmask & cfb_pkg::BIT_TIMING_WMASK);
		end
	end

	assign silent_select = bit_timing_r[cfb_pkg::SILENT_BIT];
	assign loopback_select = bit_timing_r[cfb_pkg::LOOPBACK_BIT];
	assign jump_limit = {1'b0, bit_timing_r[cfb_pkg::SJW_LSB +: 2]} + 3'h1;

	// quantum prescaler
	always_ff @(posedge aclk) begin
		if (!aresetn || control_r[cfb_pkg::CTL_INIT_BIT]) begin
			presc_cnt_r <= 10'h000;
		end else if (presc_cnt_r >= bit_timing_r[9:0]) begin
			presc_cnt_r <= 10'h000;
		end else begin
			presc_cnt_r <= presc_cnt_r + 10'h001;
		end
	end
	assign tq_tick = !control_r[cfb_pkg::CTL_INIT_BIT]
		&& presc_cnt_r >= bit_timing_r[9:0];

	// nominal bit segments
	always_ff @(posedge aclk) begin
		if (!aresetn || control_r[cfb_pkg::CTL_INIT_BIT]) begin
			seg_r <= cfb_pkg::SEG_SYNC;
			seg_cnt_r <= 4'h0;
		end else if (tq_tick) begin
			case (seg_r)
				cfb_pkg::SEG_SYNC: begin
					seg_r <= cfb_pkg::SEG_ONE;
					seg_cnt_r <= 4'h0;
				end
				cfb_pkg::SEG_ONE: begin
					if (seg_cnt_r >= bit_timing_r[cfb_pkg::SEG1_LSB +: 4]) begin
						seg_r <= cfb_pkg::SEG_TWO;
						seg_cnt_r <= 4'h0;
					end else begin
						seg_cnt_r <= seg_cnt_r + 4'h1;
					end
				end
				cfb_pkg::SEG_TWO: begin
					if (seg_cnt_r >= {1'b0, bit_timing_r[cfb_pkg::SEG2_LSB +: 3]}) begin
						seg_r <= cfb_pkg::SEG_SYNC;
						seg_cnt_r <= 4'h0;
					end else begin
						seg_cnt_r <= seg_cnt_r + 4'h1;
					end
				end
				default: begin
					seg_r <= cfb_pkg::SEG_SYNC;
					seg_cnt_r <= 4'h0;
				end
			endcase
		end
	end
	assign bit_start = tq_tick && seg_r == cfb_pkg::SEG_SYNC;
	assign sample_point = tq_tick && seg_r == cfb_pkg::SEG_ONE
		&& seg_cnt_r >= bit_timing_r[cfb_pkg::SEG1_LSB +: 4];

	// receive error count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			receive_error_count_r <= 8'h00;
		end else if (rx_err_8) begin
			receive_error_count_r <= (receive_error_count_r > 8'hf7)
				? 8'hff : receive_error_count_r + 8'h08;
		end else if (rx_err_1) begin
			if (receive_error_count_r != 8'hff) begin
				receive_error_count_r <= receive_error_count_r + 8'h01;
			end
		end else if (rx_ok) begin
			if (receive_error_count_r > cfb_pkg::PASSIVE_LIMIT[7:0]) begin
				receive_error_count_r <= cfb_pkg::RX_RELOAD;
			end else if (receive_error_count_r != 8'h00) begin
				receive_error_count_r <= receive_error_count_r - 8'h01;
			end
		end
	end

	// transmit error count, held while bus-off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			transmit_error_count_r <= 9'h000;
		end else if (bus_off_flag_r) begin
			transmit_error_count_r <= transmit_error_count_r;
		end else if (tx_err_8) begin
			transmit_error_count_r <= transmit_error_count_r + 9'h008;
		end else if (tx_ok && transmit_error_count_r != 9'h000) begin
			transmit_error_count_r <= transmit_error_count_r - 9'h001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_off_flag_r <= 1'b0;
		end else if (transmit_error_count_r > cfb_pkg::BOFF_LIMIT) begin
			bus_off_flag_r <= 1'b1;
		end
	end

	assign rx_ext = {1'b0, receive_error_count_r};
	assign passive_now = rx_ext > cfb_pkg::PASSIVE_LIMIT
		|| transmit_error_count_r > cfb_pkg::PASSIVE_LIMIT;
	assign warn_now = rx_ext >= cfb_pkg::WARN_LIMIT
		|| transmit_error_count_r >= cfb_pkg::WARN_LIMIT;
	assign error_passive_flag = passive_now;
	assign error_warning_flag = warn_now;
	assign bus_off_flag = bus_off_flag_r;

	// last error code
	assign lec_event = bus_err && bus_err_code != cfb_pkg::LEC_NONE
		&& bus_err_code != cfb_pkg::LEC_SW;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			last_error_code_r <= cfb_pkg::LEC_NONE;
		end else if (lec_event) begin
			last_error_code_r <= bus_err_code;
		end else if (rx_ok || tx_ok) begin
			last_error_code_r <= cfb_pkg::LEC_NONE;
		end else if (wr_go && aw_addr_r == cfb_pkg::ADDR_ERR_STATUS
			&& w_strb_r[0]) begin
			last_error_code_r <= w_data_r[cfb_pkg::LEC_LSB +: 3];
		end
	end

	// flag edges for the error interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			passive_d_r <= 1'b0;
			warn_d_r <= 1'b0;
		end else begin
			passive_d_r <= passive_now;
			warn_d_r <= warn_now;
		end
	end

	always_comb begin
		irq_set = 2'b00;
		irq_set[cfb_pkg::IRQ_ERR] = control_r[cfb_pkg::CTL_ERR_IE] && err_event;
		irq_set[cfb_pkg::IRQ_SAMPLE] = sample_point;
	end

	// one-cycle error event, so a clear of the status bit sticks
	assign err_event = (control_r[cfb_pkg::CTL_BOFF_IE]
		&& transmit_error_count_r > cfb_pkg::BOFF_LIMIT
		&& !bus_off_flag_r)
		|| (control_r[cfb_pkg::CTL_PASS_IE] && passive_now && !passive_d_r)
		|| (control_r[cfb_pkg::CTL_WARN_IE] && warn_now && !warn_d_r)
		|| (control_r[cfb_pkg::CTL_LEC_IE] && lec_event);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			general_error_irq_flag_r <= 1'b0;
		end else if (err_event) begin
			general_error_irq_flag_r <= 1'b1;
		end else if (wr_go && aw_addr_r == cfb_pkg::ADDR_IRQ_STATUS
			&& w_strb_r[0] && w_data_r[cfb_pkg::IRQ_ERR]) begin
			general_error_irq_flag_r <= 1'b0;
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status_r <= 2'b00;
		end else if (wr_go && aw_addr_r == cfb_pkg::ADDR_IRQ_STATUS
			&& w_strb_r[0]) begin
			irq_status_r <= (irq_status_r & ~w_data_r[1:0]) | irq_set;
		end else begin
			irq_status_r <= irq_status_r | irq_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_r <= 2'b00;
		end else if (wr_go && aw_addr_r == cfb_pkg::ADDR_IRQ_MASK
			&& w_strb_r[0]) begin
			irq_mask_r <= w_data_r[1:0];
		end
	end
	assign irq = |(irq_status_r & irq_mask_r);

	// read path
	assign err_status = {receive_error_count_r, transmit_error_count_r[7:0],
		9'h000, last_error_code_r, 1'b0, bus_off_flag_r,
		error_passive_flag, error_warning_flag};

	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			cfb_pkg::ADDR_ERR_STATUS: rd_val = err_status;
			cfb_pkg::ADDR_BIT_TIMING: rd_val = bit_timing_r;
			cfb_pkg::ADDR_CONTROL: rd_val = control_r;
			cfb_pkg::ADDR_IRQ_STATUS: rd_val = {30'h0, irq_status_r};
			cfb_pkg::ADDR_IRQ_MASK: rd_val = {30'h0, irq_mask_r};
			default: begin
				rd_val = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= cfb_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_hit ? cfb_pkg::RESP_OKAY : cfb_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ---- sim/cfb_checker.sv ----
`timescale 1ns/1ns
module cfb_checker (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// engine events
	input wire logic rx_err_1,
	input wire logic rx_err_8,
	input wire logic rx_ok,
	input wire logic tx_err_8,
	input wire logic tx_ok,
	// timing and status
	input wire logic tq_tick,
	input wire logic sample_point,
	input wire logic bit_start,
	input wire logic [2:0] jump_limit,
	input wire logic bus_off_flag,
	input wire logic error_passive_flag,
	input wire logic irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_boff_sticky: assert property (
		bus_off_flag |=> bus_off_flag) else $error("bus-off flag dropped");
	a_boff_passive: assert property (
		bus_off_flag |-> error_passive_flag) else $error("bus-off not passive");
	a_boff_cause: assert property (
		$rose(bus_off_flag) |-> $past(tx_err_8, 2) || $past(tx_err_8))
		else $error("bus-off without tx error");
	a_passive_rise: assert property (
		$rose(error_passive_flag) |-> $past(rx_err_1) || $past(rx_err_8)
		|| $past(tx_err_8)) else $error("passive rose without error");
	a_passive_fall: assert property (
		$fell(error_passive_flag) |-> $past(rx_ok) || $past(tx_ok))
		else $error("passive fell without good frame");
	a_start_tick: assert property (
		bit_start |-> tq_tick && !sample_point) else $error("bit start off tick");
	a_sample_tick: assert property (
		sample_point |-> tq_tick) else $error("sample point off tick");
	a_bit_min: assert property (
		bit_start |=> !bit_start [*2]) else $error("bit too short");
	a_jump_range: assert property (
		jump_limit != 3'h0 && jump_limit <= 3'h4) else $error("jump limit range");
	a_irq_reset: assert property (
		$rose(aresetn) |-> !irq) else $error("irq high after reset");

	c_sample: cover property (sample_point);
	c_boff: cover property ($rose(bus_off_flag));
	c_irq: cover property ($rose(irq));
	c_pass_fall: cover property ($fell(error_passive_flag));
endmodule

bind cfb_top cfb_checker u_chk (.aclk, .aresetn, .rx_err_1, .rx_err_8,
	.rx_ok, .tx_err_8, .tx_ok, .tq_tick, .sample_point, .bit_start,
	.jump_limit, .bus_off_flag, .error_passive_flag, .irq);

// ---- sim/cfb_engine_model.sv ----
`timescale 1ns/1ns
module cfb_engine_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench commands
	input wire logic go,
	input wire logic [2:0] kind,
	input wire logic [2:0] code,
	// event pulses
	output logic rx_err_1,
	output logic rx_err_8,
	output logic rx_ok,
	output logic tx_err_8,
	output logic tx_ok,
	output logic bus_err,
	output logic [2:0] bus_err_code
);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{rx_err_1, rx_err_8, rx_ok, tx_err_8, tx_ok, bus_err} <= 6'h00;
			bus_err_code <= 3'h0;
		end else begin
			rx_err_1 <= go && kind == 3'h0;
			rx_err_8 <= go && kind == 3'h1;
			rx_ok <= go && kind == 3'h2;
			tx_err_8 <= go && kind == 3'h3;
			tx_ok <= go && kind == 3'h4;
			bus_err <= go && kind == 3'h5;
			// code line churns outside error pulses
			bus_err_code <= (go && kind == 3'h5) ? code : ~bus_err_code;
		end
	end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(g, e) check_val(34'(g), 34'(e))
module tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tq_tick, sample_point, bit_start, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, bt;
	logic rx_err_1, rx_err_8, rx_ok, tx_err_8, tx_ok, bus_err;
	logic [2:0] bus_err_code, jump_limit, lec_m = 3'h0;
	logic silent_select, loopback_select, bus_off_flag, error_passive_flag;
	logic ev_go = 1'b0;
	logic boff_m = 1'b0;
	logic [2:0] ev_kind = 3'h0;
	logic [2:0] ev_code = 3'h0;
	logic [33:0] exp_q[$];
	int error_cnt = 0, checked = 0, cyc = 0, rx_m = 0, tx_m = 0;
	int n, p, t1, tp;

	cfb_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_err_1, .rx_err_8,
		.rx_ok, .tx_err_8, .tx_ok, .bus_err, .bus_err_code, .tq_tick,
		.sample_point, .bit_start, .jump_limit, .silent_select,
		.loopback_select, .bus_off_flag, .error_passive_flag, .irq);
	cfb_engine_model u_eng (.aclk, .aresetn, .go(ev_go), .kind(ev_kind),
		.code(ev_code), .rx_err_1, .rx_err_8, .rx_ok, .tx_err_8, .tx_ok,
		.bus_err, .bus_err_code);

	always #50 aclk = ~aclk;

	task automatic check_val(input logic [33:0] g, input logic [33:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// response watcher and hang limit
	always @(posedge aclk) begin
		cyc++;
		if (s_axi_bvalid && s_axi_bready)
			`CHK({s_axi_bresp, 32'h0}, exp_q.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			`CHK({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
		if (cyc == 30000) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		exp_q.push_back({r, d});
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	function automatic logic [31:0] st_exp();
		logic w, ps;
		w = rx_m >= 96 || tx_m >= 96;
		ps = rx_m > 127 || tx_m > 127;
		return {8'(rx_m), 8'(tx_m), 9'h0, lec_m, 1'b0, boff_m, ps, w};
	endfunction

	// engine events with the expected counter model
	task automatic ev(input logic [2:0] k, input logic [2:0] c, input int cnt);
		repeat (cnt) begin
			@(posedge aclk);
			ev_go <= 1'b1;
			ev_kind <= k;
			ev_code <= c;
			case (k)
			3'h0: rx_m = rx_m < 255 ? rx_m + 1 : 255;
			3'h1: rx_m = rx_m > 247 ? 255 : rx_m + 8;
			3'h2: begin
				rx_m = rx_m > 127 ? 120 : (rx_m > 0 ? rx_m - 1 : 0);
				lec_m = 3'h0;
			end
			3'h3: tx_m = boff_m ? tx_m : tx_m + 8;
			3'h4: begin
				tx_m = (boff_m || tx_m == 0) ? tx_m : tx_m - 1;
				lec_m = 3'h0;
			end
			default: lec_m = (c == 3'h0 || c == 3'h7) ? lec_m : c;
			endcase
			boff_m = boff_m || tx_m > 255;
		end
		@(posedge aclk);
		ev_go <= 1'b0;
		repeat (5) @(posedge aclk);
	endtask

	initial begin
		void'($urandom(7));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'h18, 32'h0, 2'h0);
		rd(8'h1c, cfb_pkg::BIT_TIMING_RST, 2'h0);
		rd(8'h2c, 32'h0, cfb_pkg::RESP_SLVERR);
		wr(8'h2c, 32'h1, cfb_pkg::RESP_SLVERR);
		$display("test reset done");
		bt = $urandom & 32'hfffffc03;
		p = bt[9:0] + 1;
		wr(8'h1c, bt, 2'h0);
		wr(8'h20, 32'h00008f00, 2'h0);
		wr(8'h1c, ~bt, 2'h0);
		rd(8'h1c, bt & cfb_pkg::BIT_TIMING_WMASK, 2'h0);
		`CHK(silent_select, bt[31]);
		`CHK(loopback_select, bt[30]);
		`CHK(jump_limit, 3'(bt[25:24]) + 3'h1);
		@(posedge aclk);
		while (!bit_start) @(posedge aclk);
		n = 0;
		tp = 0;
		t1 = 0;
		do begin
			@(posedge aclk);
			n++;
			if (tq_tick && tp == 0) tp = n;
			if (sample_point) t1 = n;
		end while (!bit_start);
		`CHK(tp, p);
		`CHK(t1, (bt[19:16] + 1) * p);
		`CHK(n - t1, (bt[22:20] + 2) * p);
		$display("test bit timing done");
		ev(3'h1, 3'h0, 12);
		rd(8'h18, st_exp(), 2'h0);
		ev(3'h0, 3'h0, 32);
		rd(8'h18, st_exp(), 2'h0);
		`CHK(error_passive_flag, 1'b1);
		ev(3'h2, 3'h0, 1);
		rd(8'h18, st_exp(), 2'h0);
		ev(3'h2, 3'h0, 1);
		ev(3'h0, 3'h0, 1);
		rd(8'h18, st_exp(), 2'h0);
		`CHK(irq, 1'b0);
		$display("test receive count done");
		for (int c = 1; c < 8; c++) begin
			ev(3'h5, 3'(c), 1);
			rd(8'h18, st_exp(), 2'h0);
		end
		wr(8'h18, 32'hffffffff, 2'h0);
		lec_m = 3'h7;
		rd(8'h18, st_exp(), 2'h0);
		ev(3'h4, 3'h0, 1);
		rd(8'h18, st_exp(), 2'h0);
		wr(8'h24, 32'h3, 2'h0);
		wr(8'h28, 32'h1, 2'h0);
		`CHK(irq, 1'b0);
		ev(3'h5, 3'h2, 1);
		`CHK(irq, 1'b1);
		wr(8'h28, 32'h0, 2'h0);
		`CHK(irq, 1'b0);
		wr(8'h28, 32'h1, 2'h0);
		`CHK(irq, 1'b1);
		wr(8'h24, 32'h1, 2'h0);
		`CHK(irq, 1'b0);
		$display("test error code done");
		ev(3'h3, 3'h0, 1);
		ev(3'h4, 3'h0, 1);
		rd(8'h18, st_exp(), 2'h0);
		ev(3'h3, 3'h0, 31);
		rd(8'h18, st_exp(), 2'h0);
		`CHK(bus_off_flag, 1'b0);
		wr(8'h24, 32'h1, 2'h0);
		ev(3'h3, 3'h0, 1);
		rd(8'h18, st_exp(), 2'h0);
		`CHK(bus_off_flag, 1'b1);
		`CHK(irq, 1'b1);
		ev(3'h3, 3'h0, 1);
		ev(3'h4, 3'h0, 1);
		rd(8'h18, st_exp(), 2'h0);
		$display("test transmit count done");
		final_report();
	end
endmodule
